// ---- include/lcd_driver_consts.vh ----
// Constants for the LCD segment/common driver.
// Assumes inclusion by bare name from the design files.
`ifndef LCD_DRIVER_CONSTS_VH
`define LCD_DRIVER_CONSTS_VH
// ------------------------------------------------------------
// Register map and fields
// ------------------------------------------------------------
`define LCD_MODE_ADDR 16'hFFB0
`define LCD_MODE_RESET 8'h00
`define LCD_ON_BIT 7
`define LCD_CKSEL_HI 6
`define LCD_CKSEL_LO 4
`define LCD_LOWV_BIT 3
`define LCD_DMODE_HI 2
`define LCD_DMODE_LO 0
`define LCD_PORT_CTRL_ADDR 16'hFFB2
`define LCD_PORT_CTRL_RESET 8'h00
`define LCD_PORT_HI 7
`define LCD_PORT_LO 4
// ------------------------------------------------------------
// Display memory window
// ------------------------------------------------------------
`define LCD_MEM_BASE 16'hFA58
`define LCD_MEM_LAST 16'hFA7F
`define LCD_SEGS 40
`define LCD_COMS 4
`define LCD_PORT_SEGS 16
`define LCD_PORT_FIRST 24
// ------------------------------------------------------------
// Mode codes
// ------------------------------------------------------------
`define DMODE_4DIV 3'h0
`define DMODE_3DIV_B3 3'h1
`define DMODE_2DIV 3'h2
`define DMODE_3DIV_B2 3'h3
`define DMODE_STATIC 3'h4
`define CKSEL_DIV9 3'h0
`define CKSEL_DIV8 3'h1
`define CKSEL_DIV7 3'h2
`define CKSEL_DIV6 3'h3
// ------------------------------------------------------------
// Divider widths
// ------------------------------------------------------------
`define WATCH_PRE_BITS 7
`define LCD_DIV_BITS 9
`define PRE_MAX 7'h7F
`endif

// ---- verilog/lcd_clock_divider.v ----
// Watch-timer prescaler and LCD clock selector.
// Assumes one core clock; slower rates leave here as one-cycle enables.
`timescale 1ns/100ps
`default_nettype none
`include "lcd_driver_consts.vh"
module lcd_clock_divider (
  // Clock and reset
  input wire core_clk,
  input wire reset,
  // Clock sources as enables
  input wire osc_tick,
  input wire sub_tick,
  input wire main_clock_select,
  input wire use_subsystem,
  input wire watch_operation_enable,
  input wire [2:0] clock_sel,
  // Selected LCD clock enable
  output wire panel_clock
);
  reg half_q;
  reg [`WATCH_PRE_BITS-1:0] pre_q;
  reg [`LCD_DIV_BITS-1:0] div_q;
  wire main_tick;
  wire watch_tick;
  reg sel_tap;
  wire [`LCD_DIV_BITS-1:0] div_next;

  // Main clock is half the oscillator unless the select bit is set
  assign main_tick = osc_tick & (main_clock_select | half_q);
  // Watch clock: main/2^7 or the subsystem tick; gated by watch enable
  assign watch_tick = watch_operation_enable &
    (use_subsystem ? sub_tick : (main_tick && pre_q == `PRE_MAX));
  assign div_next = div_q + {{(`LCD_DIV_BITS-1){1'b0}}, 1'b1};

  // Prescaler and LCD divider; a cleared watch enable freezes the LCD divider only, the prescaler keeps counting
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      half_q <= 1'b0;
      pre_q <= {`WATCH_PRE_BITS{1'b0}};
      div_q <= {`LCD_DIV_BITS{1'b0}};
    end else begin
      if (osc_tick)
        half_q <= ~half_q;
      if (main_tick)
        pre_q <= pre_q + {{(`WATCH_PRE_BITS-1){1'b0}}, 1'b1};
      if (watch_tick)
        div_q <= div_next;
    end
  end

  // Tap where the counter rolls over at the selected power of two
  always @* begin
    case (clock_sel)
      `CKSEL_DIV9: sel_tap = (div_q[8:0] == 9'h1FF);
      `CKSEL_DIV8: sel_tap = (div_q[7:0] == 8'hFF);
      `CKSEL_DIV7: sel_tap = (div_q[6:0] == 7'h7F);
      `CKSEL_DIV6: sel_tap = (div_q[5:0] == 6'h3F);
      default: sel_tap = 1'b0; // Prohibited codes give no clock
    endcase
  end

  assign panel_clock = watch_tick & sel_tap;
endmodule
`default_nettype wire

// ---- verilog/lcd_segment_common_driver.v ----
// LCD segment/common controller: mode registers, display memory, scan.
// Assumes a byte-wide memory-style CPU port and external level shifters
// that turn each drive code into the bias voltages.
// How it works
// - Scan reads display memory by itself; no software per refresh.
// - Five display modes: static, 1/2, 1/3 b2, 1/3 b3, 1/4 duty.
// - Forty segment outputs and four common outputs.
// - Sixteen segments switch to port use, two at a time.
// - Runs from subsystem clock tick alone.
// - Four-division mode uses all four commons, 160 pixels.
// - Eight-bit mode register, bit or byte writes, reset to zero.
// - Display off forces non-select on every segment.
// - Clock select picks watch clock over 2^9..2^6; others prohibited.
// - Mode field codes 000..100 decode to division and bias.
// - Clearing watch enable stops the LCD clock.
// - Frame rate is LCD clock over number of divisions.
// - Watch clock is main clock over 2^7 or subsystem clock.
// - Main clock is oscillator/2 or oscillator by select bit.
// - Memory bits 0..3 map to common slots 0..3; 1 selects.
// - Forty consecutive bytes, one per segment; upper four bits read zero.
// - Two-division leaves commons 2,3 open; three leaves 3 open.
`timescale 1ns/100ps
`default_nettype none
`include "lcd_driver_consts.vh"
module lcd_segment_common_driver (
  // Clock and reset
  input wire core_clk,
  input wire reset,
  // CPU memory port (byte wide, bit writes by mask)
  input wire [15:0] cpu_addr,
  input wire cpu_wr,
  input wire cpu_rd,
  input wire [7:0] cpu_wdata,
  input wire [7:0] cpu_wmask,
  output reg [7:0] cpu_rdata,
  output wire cpu_hit,
  // Clock sources and watch timer control
  input wire osc_tick,
  input wire sub_tick,
  input wire main_clock_select,
  input wire use_subsystem,
  input wire watch_operation_enable,
  // Common drive: select flag, phase, enable
  output reg [3:0] common_sel,
  output reg common_phase,
  output reg [3:0] common_oe,
  // Segment drive: select flag per segment, enable
  output reg [39:0] segment_sel,
  output reg [39:0] segment_oe,
  // Bias and power mode to the voltage generator
  output reg third_bias,
  output reg low_voltage
);
  // ----------------------------------------------------------
  // Registers and storage
  // ----------------------------------------------------------
  reg [7:0] lcd_display_mode_q;
  reg [7:0] segment_port_control_q;
  reg [3:0] mem_q [0:`LCD_SEGS-1];
  reg [3:0] slot_q;
  reg phase_q;
  wire panel_clock;
  wire display_on_bit;
  wire [2:0] dmode;
  wire [5:0] mem_idx;
  wire [15:0] mem_off;
  wire mem_hit;
  wire [7:0] mode_d;
  wire [7:0] port_d;
  localparam [3:0] SLOT0 = 4'h1;
  localparam [3:0] SLOT1 = 4'h2;
  localparam [3:0] SLOT2 = 4'h4;
  localparam [3:0] SLOT3 = 4'h8;

  // Number of active slots for a mode code
  function [2:0] slots_of;
    input [2:0] m;
    begin
      case (m)
        `DMODE_4DIV: slots_of = 3'h4;
        `DMODE_3DIV_B3: slots_of = 3'h3;
        `DMODE_3DIV_B2: slots_of = 3'h3;
        `DMODE_2DIV: slots_of = 3'h2;
        default: slots_of = 3'h1;
      endcase
    end
  endfunction

  // Bias for a mode code
  function is_third_bias;
    input [2:0] m;
    begin
      is_third_bias = (m == `DMODE_4DIV) || (m == `DMODE_3DIV_B3);
    end
  endfunction

  assign display_on_bit = lcd_display_mode_q[`LCD_ON_BIT];
  assign dmode = lcd_display_mode_q[`LCD_DMODE_HI:`LCD_DMODE_LO];
  assign mem_hit = (cpu_addr >= `LCD_MEM_BASE) && (cpu_addr <= `LCD_MEM_LAST);
  // Full-width offset, then cut: only six bits matter inside the window
  assign mem_off = cpu_addr - `LCD_MEM_BASE;
  assign mem_idx = mem_hit ? mem_off[5:0] : 6'h00;
  assign cpu_hit = mem_hit || (cpu_addr == `LCD_MODE_ADDR) ||
    (cpu_addr == `LCD_PORT_CTRL_ADDR);
  // Masked write merges so single-bit manipulation leaves the rest
  assign mode_d = (lcd_display_mode_q & ~cpu_wmask) | (cpu_wdata & cpu_wmask);
  assign port_d = (segment_port_control_q & ~cpu_wmask) | (cpu_wdata & cpu_wmask);

  // ----------------------------------------------------------
  // LCD clock
  // ----------------------------------------------------------
  lcd_clock_divider u_div (
    .core_clk(core_clk),
    .reset(reset),
    .osc_tick(osc_tick),
    .sub_tick(sub_tick),
    .main_clock_select(main_clock_select),
    .use_subsystem(use_subsystem),
    .watch_operation_enable(watch_operation_enable),
    .clock_sel(lcd_display_mode_q[`LCD_CKSEL_HI:`LCD_CKSEL_LO]),
    .panel_clock(panel_clock)
  );

  // Control registers
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      lcd_display_mode_q <= `LCD_MODE_RESET;
      segment_port_control_q <= `LCD_PORT_CTRL_RESET;
    end else if (cpu_wr) begin
      if (cpu_addr == `LCD_MODE_ADDR)
        lcd_display_mode_q <= mode_d;
      if (cpu_addr == `LCD_PORT_CTRL_ADDR)
        segment_port_control_q <= {port_d[7:4], 2'b00, port_d[1:0]};
    end
  end

  // Display memory: low nibble stored only, upper bits read zero
  genvar g;
  generate
    for (g = 0; g < `LCD_SEGS; g = g + 1) begin : mem
      always @(posedge core_clk or posedge reset) begin
        if (reset)
          mem_q[g] <= 4'h0;
        else if (cpu_wr && mem_hit && mem_idx == g)
          mem_q[g] <= (mem_q[g] & ~cpu_wmask[3:0]) | (cpu_wdata[3:0] & cpu_wmask[3:0]);
      end
    end
  endgenerate

  // Read path
  always @(posedge core_clk or posedge reset) begin
    if (reset)
      cpu_rdata <= 8'h00;
    else if (cpu_rd) begin
      if (mem_hit)
        cpu_rdata <= {4'h0, mem_q[mem_idx]};
      else if (cpu_addr == `LCD_MODE_ADDR)
        cpu_rdata <= lcd_display_mode_q;
      else if (cpu_addr == `LCD_PORT_CTRL_ADDR)
        cpu_rdata <= segment_port_control_q;
      else
        cpu_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------
  // Slot sequencer
  // ----------------------------------------------------------
  // One slot per LCD clock, so frame = LCD clock / divisions
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      slot_q <= SLOT0;
      phase_q <= 1'b0;
    end else if (panel_clock) begin
      case (slot_q)
        SLOT0: slot_q <= (slots_of(dmode) > 3'h1) ? SLOT1 : SLOT0;
        SLOT1: slot_q <= (slots_of(dmode) > 3'h2) ? SLOT2 : SLOT0;
        SLOT2: slot_q <= (slots_of(dmode) > 3'h3) ? SLOT3 : SLOT0;
        SLOT3: slot_q <= SLOT0;
        default: slot_q <= SLOT0;
      endcase
      // Frame end flips polarity so the panel sees no DC
      if (slot_q == SLOT0 && slots_of(dmode) == 3'h1)
        phase_q <= ~phase_q;
      else if (slot_q != SLOT0 && ((slot_q == SLOT1 && slots_of(dmode) == 3'h2) ||
               (slot_q == SLOT2 && slots_of(dmode) == 3'h3) || slot_q == SLOT3))
        phase_q <= ~phase_q;
    end
  end

  // ----------------------------------------------------------
  // Output drive, registered
  // ----------------------------------------------------------
  integer i;
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      common_sel <= 4'h0;
      common_phase <= 1'b0;
      common_oe <= 4'h0;
      segment_sel <= 40'h00_0000_0000;
      segment_oe <= 40'h00_0000_0000;
      third_bias <= 1'b0;
      low_voltage <= 1'b0;
    end else begin
      common_phase <= phase_q;
      third_bias <= is_third_bias(dmode);
      low_voltage <= lcd_display_mode_q[`LCD_LOWV_BIT];
      // Static mode drives one waveform on all commons
      common_sel <= (slots_of(dmode) == 3'h1) ? 4'hF : slot_q;
      case (slots_of(dmode))
        3'h2: common_oe <= 4'h3;
        3'h3: common_oe <= 4'h7;
        default: common_oe <= 4'hF;
      endcase
      for (i = 0; i < `LCD_SEGS; i = i + 1) begin
        // Bit n of each byte shown in slot n; off forces non-select
        segment_sel[i] <= display_on_bit & |(mem_q[i] & slot_q);
        // Fixed segments always drive; shared pins open pairwise upward, bad counts give none
        segment_oe[i] <= (i < `LCD_PORT_FIRST) ||
          ((segment_port_control_q[`LCD_PORT_HI:`LCD_PORT_LO] <= `LCD_PORT_SEGS / 2) &&
          ((i - `LCD_PORT_FIRST) / 2 < segment_port_control_q[`LCD_PORT_HI:`LCD_PORT_LO]));
      end
    end
  end
endmodule
`default_nettype wire

// ---- bench/lcd_driver_monitor.sv ----
// Port checker for the LCD segment/common driver.
// Assumes the constants header is on the include path.
`timescale 1ns/100ps
`default_nettype none
`include "lcd_driver_consts.vh"
module lcd_driver_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // CPU port
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  input wire logic [7:0] cpu_wmask,
  input wire logic [7:0] cpu_rdata,
  input wire logic cpu_hit,
  input wire logic watch_operation_enable,
  // Drive outputs
  input wire logic [3:0] common_sel,
  input wire logic common_phase,
  input wire logic [3:0] common_oe,
  input wire logic [39:0] segment_sel,
  input wire logic [39:0] segment_oe,
  input wire logic third_bias
);
  logic on_q;
  wire mem_a;
  assign mem_a = cpu_addr >= `LCD_MEM_BASE && cpu_addr <= `LCD_MEM_LAST;
  // Shadow of the display-on bit, updated like the real register
  always @(posedge core_clk or posedge reset) begin
    if (reset)
      on_q <= 1'b0;
    else if (cpu_wr && cpu_addr == `LCD_MODE_ADDR && cpu_wmask[`LCD_ON_BIT])
      on_q <= cpu_wdata[`LCD_ON_BIT];
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_unmapped; cpu_rd && !cpu_hit |=> cpu_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_mem_hi; cpu_rd && mem_a |=> cpu_rdata[7:4] == 4'h0; endproperty
  a_mem_hi: assert property (p_mem_hi) else $error("memory upper nibble set");
  property p_hit;
    cpu_hit == (cpu_addr == `LCD_MODE_ADDR || cpu_addr == `LCD_PORT_CTRL_ADDR || mem_a);
  endproperty
  a_hit: assert property (p_hit) else $error("address decode wrong");
  property p_pairs;
    !$past(reset) |-> segment_oe[39:24] inside {16'h0000, 16'h0003, 16'h000F, 16'h003F,
      16'h00FF, 16'h03FF, 16'h0FFF, 16'h3FFF, 16'hFFFF} && &segment_oe[23:0];
  endproperty
  a_pairs: assert property (p_pairs) else $error("segment enables not pairwise");
  property p_bias; common_oe == 4'h3 |-> !third_bias; endproperty
  a_bias: assert property (p_bias) else $error("two-division mode not half bias");
  // Frame end always returns the scan to the first common
  property p_phase;
    !$past(reset) && $changed(common_phase) && common_sel != 4'hF && !$past(cpu_wr)
      && !$past(cpu_wr, 2) |-> common_sel == 4'h1;
  endproperty
  a_phase: assert property (p_phase) else $error("frame ended off slot zero");
  property p_stop;
    !$past(watch_operation_enable) && !$past(watch_operation_enable, 2)
      && !$past(watch_operation_enable, 3) && !$past(cpu_wr) && !$past(cpu_wr, 2)
      |-> $stable(common_sel) && $stable(common_phase);
  endproperty
  a_stop: assert property (p_stop) else $error("scan moved with watch stopped");
  property p_off; !on_q && !$past(on_q) |-> segment_sel == 40'h0; endproperty
  a_off: assert property (p_off) else $error("segment selected while off");
  c_two: cover property (common_oe == 4'h3);
  c_frame: cover property ($changed(common_phase) && common_sel == 4'h1);
  c_unmapped: cover property (cpu_rd && !cpu_hit);
endmodule
bind lcd_segment_common_driver lcd_driver_monitor i_mon (.core_clk(core_clk), .reset(reset),
  .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata),
  .cpu_wmask(cpu_wmask), .cpu_rdata(cpu_rdata), .cpu_hit(cpu_hit),
  .watch_operation_enable(watch_operation_enable), .common_sel(common_sel),
  .common_phase(common_phase), .common_oe(common_oe), .segment_sel(segment_sel),
  .segment_oe(segment_oe), .third_bias(third_bias));
`default_nettype wire

// ---- bench/lcd_panel_model.sv ----
// Panel model: which pixels light in the current slot.
// Assumes the drive codes of the controller, one flag per electrode.
`timescale 1ns/100ps
`default_nettype none
module lcd_panel_model (
  // Electrode drive
  input wire logic [3:0] common_sel,
  input wire logic [3:0] common_oe,
  input wire logic [39:0] segment_sel,
  input wire logic [39:0] segment_oe,
  // Lit pixels
  output logic [39:0] lit
);
  // Select on both electrodes lights; an open common lights nothing
  assign lit = segment_sel & segment_oe & {40{|(common_sel & common_oe)}};
endmodule
`default_nettype wire

// ---- bench/lcd_segment_common_driver_tb.sv ----
// Self-checking bench for the LCD driver with panel model and checker.
// Assumes ticks every cycle; subsystem path gives one slot per 2^(9-sel) cycles.
`timescale 1ns/100ps
`default_nettype none
module lcd_segment_common_driver_tb;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] cpu_addr = 16'h0000;
  logic cpu_wr = 1'b0;
  logic cpu_rd = 1'b0;
  logic [7:0] cpu_wdata = 8'h00;
  logic [7:0] cpu_wmask = 8'h00;
  logic osc_tick = 1'b1;
  logic sub_tick = 1'b1;
  logic main_clock_select = 1'b1;
  logic use_subsystem = 1'b1;
  logic watch_operation_enable = 1'b1;
  wire [7:0] cpu_rdata;
  wire cpu_hit, common_phase, third_bias, low_voltage;
  wire [3:0] common_sel, common_oe;
  wire [39:0] segment_sel, segment_oe, lit;
  int n_mismatch = 0;
  int n_tests = 0;
  int i, j, n;
  logic [7:0] rv;
  logic [3:0] s;
  // Rows: address, data, mask, expected readback
  logic [39:0] rows [7] = '{40'hFFB0A5FFA5, 40'hFFB0008025, 40'hFFB2FFFFF3, 40'hFA58FFFF0F,
    40'hFA7F3CFF0C, 40'hFA5755FF00, 40'hFFB155FF00};
  logic [3:0] oe_x [5] = '{4'hF, 4'h7, 4'h3, 4'h7, 4'hF};
  int div_x [5] = '{4, 3, 2, 3, 1};
  lcd_segment_common_driver i_dut (.core_clk(core_clk), .reset(reset), .cpu_addr(cpu_addr),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_wmask(cpu_wmask),
    .cpu_rdata(cpu_rdata), .cpu_hit(cpu_hit), .osc_tick(osc_tick), .sub_tick(sub_tick),
    .main_clock_select(main_clock_select), .use_subsystem(use_subsystem),
    .watch_operation_enable(watch_operation_enable), .common_sel(common_sel),
    .common_phase(common_phase), .common_oe(common_oe), .segment_sel(segment_sel),
    .segment_oe(segment_oe), .third_bias(third_bias), .low_voltage(low_voltage));
  lcd_panel_model i_panel (.common_sel(common_sel), .common_oe(common_oe),
    .segment_sel(segment_sel), .segment_oe(segment_oe), .lit(lit));
  // 10 MHz core clock
  always #50 core_clk = ~core_clk;
  task wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m);
    begin
      @(posedge core_clk);
      cpu_addr <= a;
      cpu_wdata <= d;
      cpu_wmask <= m;
      cpu_wr <= 1'b1;
      @(posedge core_clk);
      cpu_wr <= 1'b0;
    end
  endtask
  task rd(input logic [15:0] a, output logic [7:0] d);
    begin
      @(posedge core_clk);
      cpu_addr <= a;
      cpu_rd <= 1'b1;
      @(posedge core_clk);
      cpu_rd <= 1'b0;
      @(negedge core_clk);
      d = cpu_rdata;
    end
  endtask
  task chk(input string what, input logic [39:0] x, input logic [39:0] g);
    begin
      n_tests++;
      if (g !== x) begin
        n_mismatch++;
        $display("FAIL %s expected %h seen %h", what, x, g);
      end
    end
  endtask
  // Cycles between two polarity flips; skipping to the first flip hides partial frames
  task frame(output int c);
    logic p;
    begin
      c = 0;
      p = common_phase;
      for (j = 0; j < 40000 && common_phase === p; j++) @(negedge core_clk);
      p = common_phase;
      for (j = 0; j < 40000 && common_phase === p; j++) begin
        @(negedge core_clk);
        c++;
      end
    end
  endtask
  task stop_test;
    begin
      $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // Watchdog well past the expected run of about 60k cycles
  initial begin
    #10_000_000;
    n_mismatch++;
    stop_test;
  end
  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    // Outputs load at the first edge after release, so look after the second
    repeat (2) @(negedge core_clk);
    chk("common_oe", 4'hF, common_oe);
    chk("segment_oe", {16'h0000, 24'hFFFFFF}, segment_oe);
    rd(16'hFFB0, rv);
    chk("mode reset", 8'h00, rv);
    for (i = 0; i < 7; i++) begin
      wr(rows[i][39:24], rows[i][23:16], rows[i][15:8]);
      rd(rows[i][39:24], rv);
      chk("readback", rows[i][7:0], rv);
    end
    chk("segment_oe", {16'h0000, 24'hFFFFFF}, segment_oe);
    wr(16'hFFB2, 8'h30, 8'hFF);
    repeat (2) @(negedge core_clk);
    chk("segment_oe", {16'h003F, 24'hFFFFFF}, segment_oe);
    // Scan: byte 0 lights slots 0 and 2, byte 39 (a port pin here, so unlit) selects slots 1 and 3
    wr(16'hFA58, 8'h05, 8'hFF);
    wr(16'hFA7F, 8'h0A, 8'hFF);
    wr(16'hFFB0, 8'hB0, 8'hFF);
    for (i = 0; i < 4; i++) begin
      for (n = 0; n < 300 && common_sel !== (4'h1 << i); n++) @(negedge core_clk);
      chk("segments", {1'(4'hA >> i), 1'(4'h5 >> i)}, {segment_sel[39], segment_sel[0]});
      chk("lit", 4'h5 >> i & 1'b1, lit[0]);
    end
    chk("third_bias", 1'b1, third_bias);
    wr(16'hFFB0, 8'h00, 8'h80);
    repeat (3) @(negedge core_clk);
    chk("display off", 40'h0, segment_sel);
    // Low-voltage bit is only set while the display is off
    wr(16'hFFB0, 8'h08, 8'h08);
    repeat (2) @(negedge core_clk);
    chk("low_voltage", 1'b1, low_voltage);
    for (i = 0; i < 5; i++) begin
      wr(16'hFFB0, 8'hB0 | i[7:0], 8'hFF);
      frame(n);
      frame(n);
      chk("frame", div_x[i] * 64, n);
      chk("common_oe", oe_x[i], common_oe);
    end
    for (i = 0; i < 4; i++) begin
      wr(16'hFFB0, 8'h82 | (i[7:0] << 4), 8'hFF);
      frame(n);
      frame(n);
      chk("clock select", 2 << (9 - i), n);
    end
    chk("third_bias", 1'b0, third_bias);
    wr(16'hFFB0, 8'hC0, 8'hFF);
    // Let a slot step launched before the write settle first
    repeat (3) @(negedge core_clk);
    s = common_sel;
    repeat (1100) @(negedge core_clk);
    chk("prohibited clock", s, common_sel);
    wr(16'hFFB0, 8'hB0, 8'hFF);
    @(posedge core_clk);
    watch_operation_enable <= 1'b0;
    repeat (3) @(negedge core_clk);
    s = common_sel;
    repeat (300) @(negedge core_clk);
    chk("watch stopped", s, common_sel);
    wr(16'hFFB0, 8'hB4, 8'hFF);
    @(posedge core_clk);
    watch_operation_enable <= 1'b1;
    use_subsystem <= 1'b0;
    frame(n);
    chk("main full rate", 128 * 64, n);
    @(posedge core_clk);
    main_clock_select <= 1'b0;
    frame(n);
    chk("main half rate", 256 * 64, n);
    stop_test;
  end
endmodule
`default_nettype wire
